/* File: inc/mirb_defs.svh */
// register indices, bit positions, codes and reset values of the interrupt bank
`ifndef MIRB_DEFS_SVH
`define MIRB_DEFS_SVH

`define MIRB_REG_EDGE      3'h0
`define MIRB_REG_CTRL0     3'h1
`define MIRB_REG_CTRL1     3'h2
`define MIRB_REG_CTRL2     3'h3
`define MIRB_REG_GRPA      3'h4
`define MIRB_REG_GRPB      3'h5

`define MIRB_B_GLOBAL      0
`define MIRB_B_EXT_EN      1
`define MIRB_B_TOUCH_EN    2
`define MIRB_B_GRP0_EN     3
`define MIRB_B_EXT_F       4
`define MIRB_B_TOUCH_F     5
`define MIRB_B_GRP0_F      6

`define MIRB_B_SERIAL_EN   0
`define MIRB_B_TBA_EN      1
`define MIRB_B_TBB_EN      2
`define MIRB_B_EEP_EN      3
`define MIRB_B_SERIAL_F    4
`define MIRB_B_TBA_F       5
`define MIRB_B_TBB_F       6
`define MIRB_B_EEP_F       7

`define MIRB_B_GRP1_EN     0
`define MIRB_B_GRP1_F      4

`define MIRB_B_TMR_P_EN    0
`define MIRB_B_TMR_A_EN    1
`define MIRB_B_TMR_P_F     4
`define MIRB_B_TMR_A_F     5

`define MIRB_F_EDGE_HI     1
`define MIRB_F_EDGE_LO     0

`define MIRB_EDGE_OFF      2'h0
`define MIRB_EDGE_RISE     2'h1
`define MIRB_EDGE_FALL     2'h2
`define MIRB_EDGE_BOTH     2'h3

`define MIRB_VEC_EXT       3'h0
`define MIRB_VEC_TOUCH     3'h1
`define MIRB_VEC_GRP0      3'h2
`define MIRB_VEC_SERIAL    3'h3
`define MIRB_VEC_TBA       3'h4
`define MIRB_VEC_TBB       3'h5
`define MIRB_VEC_EEP       3'h6
`define MIRB_VEC_GRP1      3'h7

`define MIRB_RESET_BYTE    8'h00

`endif

/* File: inc/mirb_pkg.sv */
// types of the interrupt request and enable bank
`default_nettype none
package mirb_pkg;

  typedef struct packed {
    logic [1:0] edge_sel;
    logic       global_en;
    logic       ext_f;
    logic       touch_f;
    logic       grp0_f;
    logic       grp1_f;
    logic       serial_f;
    logic       tba_f;
    logic       tbb_f;
    logic       eep_f;
    logic       pa_f;
    logic       pp_f;
    logic       ca_f;
    logic       cp_f;
    logic       ext_en;
    logic       touch_en;
    logic       grp0_en;
    logic       grp1_en;
    logic       serial_en;
    logic       tba_en;
    logic       tbb_en;
    logic       eep_en;
    logic       pa_en;
    logic       pp_en;
    logic       ca_en;
    logic       cp_en;
    logic       pin_meta;
    logic       pin_sync;
    logic       pin_prev;
    logic [7:0] rdata;
  } mirb_state_t;

endpackage
`default_nettype wire

/* File: core/mirb_bank.sv */
// interrupt request flags, enables and edge select of the microcontroller
`timescale 1ns/10ps
`default_nettype none
`include "mirb_defs.svh"

// What this block does
// - edge select off, rise, fall or both
// - control0 bit 0 is global enable
// - control0 holds group0, touch, pin flags/enables
// - large variant: control2 group1 flag/enable
// - large variant: compact timer A/P flags, enables
// - unimplemented bits read zero, ignore writes
// - hardware sets flags; software writes enables
// - accept pin and internal source requests
// - request taken only when own enable set
// - servicing clears global enable automatically
// - group flag set when an enabled member flag sets
// - servicing group clears only group flag
module mirb_bank
  import mirb_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
)
(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic [2:0] reg_sel,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       ext_pin,
  input  wire logic       touch_evt,
  input  wire logic       serial_evt,
  input  wire logic       tba_evt,
  input  wire logic       tbb_evt,
  input  wire logic       eeprom_evt,
  input  wire logic       pa_evt,
  input  wire logic       pp_evt,
  input  wire logic       ca_evt,
  input  wire logic       cp_evt,
  input  wire logic       irq_ack,
  input  wire logic [2:0] irq_ack_vec,
  output logic      [7:0] irq_pending,
  output logic            irq_request
);

  mirb_state_t st;
  mirb_state_t next_st;

  logic wr_edge;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_ctrl2;
  logic wr_grpa;
  logic wr_grpb;
  logic pin_rise;
  logic pin_fall;
  logic ext_evt;
  logic [7:0] ack_hit;
  logic [7:0] rd_mux;

  // set beats a clear arriving in the same cycle, so no event is lost
  // order: service clear, then software write, then hardware set
  function automatic logic mirb_flag(
    input logic cur,
    input logic wr_hit,
    input logic wr_bit,
    input logic set_evt,
    input logic ack_clr
  );
    logic r;
    r = cur;
    if (ack_clr)
    begin
      r = 1'b0;
    end
    if (wr_hit)
    begin
      r = wr_bit;
    end
    mirb_flag = r | set_evt;
  endfunction

  // small part: control2 and timer group b ignore writes and read zero
  assign wr_edge  = reg_wr && (reg_sel == `MIRB_REG_EDGE);
  assign wr_ctrl0 = reg_wr && (reg_sel == `MIRB_REG_CTRL0);
  assign wr_ctrl1 = reg_wr && (reg_sel == `MIRB_REG_CTRL1);
  assign wr_ctrl2 = reg_wr && (reg_sel == `MIRB_REG_CTRL2) && LARGE_VARIANT;
  assign wr_grpa  = reg_wr && (reg_sel == `MIRB_REG_GRPA);
  assign wr_grpb  = reg_wr && (reg_sel == `MIRB_REG_GRPB) && LARGE_VARIANT;

  // edge found on the second synchroniser stage only
  // pin history resets low: a pin already high at release reads as a rise
  // about three cycles later; harmless unless edge select is written first
  assign pin_rise = st.pin_sync & ~st.pin_prev;
  assign pin_fall = ~st.pin_sync & st.pin_prev;

  always_comb
  begin
    case (st.edge_sel)
      `MIRB_EDGE_OFF:  ext_evt = 1'b0;
      `MIRB_EDGE_RISE: ext_evt = pin_rise;
      `MIRB_EDGE_FALL: ext_evt = pin_fall;
      `MIRB_EDGE_BOTH: ext_evt = pin_rise | pin_fall;
      default:         ext_evt = 1'b0;
    endcase
  end

  // only vectors with a flag of their own are cleared; timer members never are
  always_comb
  begin
    ack_hit = 8'h00;
    if (irq_ack)
    begin
      ack_hit[irq_ack_vec] = 1'b1;
    end
  end

  // a vector is offered only with its own enable and the global enable
  always_comb
  begin
    irq_pending                 = 8'h00;
    irq_pending[`MIRB_VEC_EXT]    = st.ext_f & st.ext_en;
    irq_pending[`MIRB_VEC_TOUCH]  = st.touch_f & st.touch_en;
    irq_pending[`MIRB_VEC_GRP0]   = st.grp0_f & st.grp0_en;
    irq_pending[`MIRB_VEC_SERIAL] = st.serial_f & st.serial_en;
    irq_pending[`MIRB_VEC_TBA]    = st.tba_f & st.tba_en;
    irq_pending[`MIRB_VEC_TBB]    = st.tbb_f & st.tbb_en;
    irq_pending[`MIRB_VEC_EEP]    = st.eep_f & st.eep_en;
    irq_pending[`MIRB_VEC_GRP1]   = st.grp1_f & st.grp1_en & LARGE_VARIANT;
    if (!st.global_en)
    begin
      irq_pending = 8'h00;
    end
  end

  assign irq_request = |irq_pending;

  // read data is registered, one cycle behind the strobe, held until the next read
  always_comb
  begin
    rd_mux = `MIRB_RESET_BYTE;
    case (reg_sel)
      `MIRB_REG_EDGE:
      begin
        rd_mux[`MIRB_F_EDGE_HI:`MIRB_F_EDGE_LO] = st.edge_sel;
      end
      `MIRB_REG_CTRL0:
      begin
        rd_mux[`MIRB_B_GLOBAL]   = st.global_en;
        rd_mux[`MIRB_B_EXT_EN]   = st.ext_en;
        rd_mux[`MIRB_B_TOUCH_EN] = st.touch_en;
        rd_mux[`MIRB_B_GRP0_EN]  = st.grp0_en;
        rd_mux[`MIRB_B_EXT_F]    = st.ext_f;
        rd_mux[`MIRB_B_TOUCH_F]  = st.touch_f;
        rd_mux[`MIRB_B_GRP0_F]   = st.grp0_f;
      end
      `MIRB_REG_CTRL1:
      begin
        rd_mux[`MIRB_B_SERIAL_EN] = st.serial_en;
        rd_mux[`MIRB_B_TBA_EN]    = st.tba_en;
        rd_mux[`MIRB_B_TBB_EN]    = st.tbb_en;
        rd_mux[`MIRB_B_EEP_EN]    = st.eep_en;
        rd_mux[`MIRB_B_SERIAL_F]  = st.serial_f;
        rd_mux[`MIRB_B_TBA_F]     = st.tba_f;
        rd_mux[`MIRB_B_TBB_F]     = st.tbb_f;
        rd_mux[`MIRB_B_EEP_F]     = st.eep_f;
      end
      `MIRB_REG_CTRL2:
      begin
        rd_mux[`MIRB_B_GRP1_EN] = st.grp1_en & LARGE_VARIANT;
        rd_mux[`MIRB_B_GRP1_F]  = st.grp1_f & LARGE_VARIANT;
      end
      `MIRB_REG_GRPA:
      begin
        rd_mux[`MIRB_B_TMR_P_EN] = st.pp_en;
        rd_mux[`MIRB_B_TMR_A_EN] = st.pa_en;
        rd_mux[`MIRB_B_TMR_P_F]  = st.pp_f;
        rd_mux[`MIRB_B_TMR_A_F]  = st.pa_f;
      end
      `MIRB_REG_GRPB:
      begin
        rd_mux[`MIRB_B_TMR_P_EN] = st.cp_en & LARGE_VARIANT;
        rd_mux[`MIRB_B_TMR_A_EN] = st.ca_en & LARGE_VARIANT;
        rd_mux[`MIRB_B_TMR_P_F]  = st.cp_f & LARGE_VARIANT;
        rd_mux[`MIRB_B_TMR_A_F]  = st.ca_f & LARGE_VARIANT;
      end
      default:
      begin
        rd_mux = `MIRB_RESET_BYTE;
      end
    endcase
  end

  always_comb
  begin
    next_st = st;

    next_st.pin_meta = ext_pin;
    next_st.pin_sync = st.pin_meta;
    next_st.pin_prev = st.pin_sync;

    if (wr_edge)
    begin
      next_st.edge_sel = reg_wdata[`MIRB_F_EDGE_HI:`MIRB_F_EDGE_LO];
    end

    // servicing drops the global enable; a same-cycle write still lands
    if (irq_ack)
    begin
      next_st.global_en = 1'b0;
    end
    if (wr_ctrl0)
    begin
      next_st.global_en = reg_wdata[`MIRB_B_GLOBAL];
      next_st.ext_en    = reg_wdata[`MIRB_B_EXT_EN];
      next_st.touch_en  = reg_wdata[`MIRB_B_TOUCH_EN];
      next_st.grp0_en   = reg_wdata[`MIRB_B_GRP0_EN];
    end
    if (wr_ctrl1)
    begin
      next_st.serial_en = reg_wdata[`MIRB_B_SERIAL_EN];
      next_st.tba_en    = reg_wdata[`MIRB_B_TBA_EN];
      next_st.tbb_en    = reg_wdata[`MIRB_B_TBB_EN];
      next_st.eep_en    = reg_wdata[`MIRB_B_EEP_EN];
    end
    if (wr_ctrl2)
    begin
      next_st.grp1_en = reg_wdata[`MIRB_B_GRP1_EN];
    end
    if (wr_grpa)
    begin
      next_st.pp_en = reg_wdata[`MIRB_B_TMR_P_EN];
      next_st.pa_en = reg_wdata[`MIRB_B_TMR_A_EN];
    end
    if (wr_grpb)
    begin
      next_st.cp_en = reg_wdata[`MIRB_B_TMR_P_EN];
      next_st.ca_en = reg_wdata[`MIRB_B_TMR_A_EN];
    end

    // source flags: hardware sets, software writes, service clears own vector
    next_st.ext_f    = mirb_flag(st.ext_f, wr_ctrl0, reg_wdata[`MIRB_B_EXT_F],
                                 ext_evt, ack_hit[`MIRB_VEC_EXT]);
    next_st.touch_f  = mirb_flag(st.touch_f, wr_ctrl0, reg_wdata[`MIRB_B_TOUCH_F],
                                 touch_evt, ack_hit[`MIRB_VEC_TOUCH]);
    next_st.serial_f = mirb_flag(st.serial_f, wr_ctrl1, reg_wdata[`MIRB_B_SERIAL_F],
                                 serial_evt, ack_hit[`MIRB_VEC_SERIAL]);
    next_st.tba_f    = mirb_flag(st.tba_f, wr_ctrl1, reg_wdata[`MIRB_B_TBA_F],
                                 tba_evt, ack_hit[`MIRB_VEC_TBA]);
    next_st.tbb_f    = mirb_flag(st.tbb_f, wr_ctrl1, reg_wdata[`MIRB_B_TBB_F],
                                 tbb_evt, ack_hit[`MIRB_VEC_TBB]);
    next_st.eep_f    = mirb_flag(st.eep_f, wr_ctrl1, reg_wdata[`MIRB_B_EEP_F],
                                 eeprom_evt, ack_hit[`MIRB_VEC_EEP]);

    // timer flags are never cleared by service, software must do it
    next_st.pa_f = mirb_flag(st.pa_f, wr_grpa, reg_wdata[`MIRB_B_TMR_A_F],
                             pa_evt, 1'b0);
    next_st.pp_f = mirb_flag(st.pp_f, wr_grpa, reg_wdata[`MIRB_B_TMR_P_F],
                             pp_evt, 1'b0);
    next_st.ca_f = mirb_flag(st.ca_f, wr_grpb, reg_wdata[`MIRB_B_TMR_A_F],
                             ca_evt & LARGE_VARIANT, 1'b0);
    next_st.cp_f = mirb_flag(st.cp_f, wr_grpb, reg_wdata[`MIRB_B_TMR_P_F],
                             cp_evt & LARGE_VARIANT, 1'b0);

    // group flag follows a member flag going from clear to set with its enable
    next_st.grp0_f = mirb_flag(st.grp0_f, wr_ctrl0, reg_wdata[`MIRB_B_GRP0_F],
                               (next_st.pa_f & ~st.pa_f & st.pa_en) |
                               (next_st.pp_f & ~st.pp_f & st.pp_en),
                               ack_hit[`MIRB_VEC_GRP0]);
    next_st.grp1_f = mirb_flag(st.grp1_f, wr_ctrl2, reg_wdata[`MIRB_B_GRP1_F],
                               (next_st.ca_f & ~st.ca_f & st.ca_en) |
                               (next_st.cp_f & ~st.cp_f & st.cp_en),
                               ack_hit[`MIRB_VEC_GRP1]) & LARGE_VARIANT;

    if (reg_rd)
    begin
      next_st.rdata = rd_mux;
    end
  end

  // one register stage for the whole state record
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;

endmodule
`default_nettype wire

/* File: tb/mirb_bank_asserts.sv */
// assertion checker for the interrupt request and enable bank
`timescale 1ns/10ps
`default_nettype none
module mirb_bank_asserts
(
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic [2:0] reg_sel,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq_ack,
  input wire logic [7:0] irq_pending,
  input wire logic       irq_request
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  a_req_or: assert property (irq_request == (|irq_pending))
    else $error("request is not the or of pending");
  // a ctrl0 write in the ack cycle may set the global enable again
  a_ack_quiet: assert property (irq_ack && !(reg_wr && reg_sel == 3'h1) |=> irq_pending == 8'h00)
    else $error("pending after service");
  a_rd_unmapped: assert property (reg_rd && reg_sel[2:1] == 2'h3 |=> reg_rdata == 8'h00)
    else $error("unmapped index reads nonzero");
  a_edge_unused: assert property (reg_rd && reg_sel == 3'h0 |=> reg_rdata[7:2] == 6'h00)
    else $error("edge select upper bits nonzero");
  a_ctrl0_top: assert property (reg_rd && reg_sel == 3'h1 |=> !reg_rdata[7])
    else $error("ctrl0 bit 7 nonzero");
  a_ctrl2_mask: assert property (reg_rd && reg_sel == 3'h3 |=> (reg_rdata & 8'hee) == 8'h00)
    else $error("ctrl2 unused bits nonzero");
  a_grp_mask: assert property (reg_rd && reg_sel inside {3'h4, 3'h5} |=> (reg_rdata & 8'hcc) == 8'h00)
    else $error("timer group unused bits nonzero");
  a_ctrl0_gate: assert property (reg_wr && reg_sel == 3'h1 |=>
    (irq_pending[2:0] & ~({3{$past(reg_wdata[0])}} & $past(reg_wdata[3:1]))) == 3'h0)
    else $error("ctrl0 source pending without enables");
  a_ctrl1_gate: assert property (reg_wr && reg_sel == 3'h2 |=>
    (irq_pending[6:3] & ~$past(reg_wdata[3:0])) == 4'h0)
    else $error("ctrl1 source pending without enable");
  a_ctrl0_pend: assert property (reg_rd && reg_sel == 3'h1 |=>
    $past(irq_pending[2:0]) == ({3{reg_rdata[0]}} & reg_rdata[6:4] & reg_rdata[3:1]))
    else $error("ctrl0 pending differs from flag and enables");
  a_ctrl1_pend: assert property (reg_rd && reg_sel == 3'h2 |=>
    ($past(irq_pending[6:3]) & ~(reg_rdata[7:4] & reg_rdata[3:0])) == 4'h0)
    else $error("ctrl1 pending without flag and enable");

  c_ack: cover property (irq_ack);
  c_grp_wr: cover property (reg_wr && reg_sel == 3'h4);
  c_request: cover property (irq_request);
endmodule

bind mirb_bank mirb_bank_asserts u_chk (.clock(clock), .nrst(nrst), .reg_sel(reg_sel), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_ack(irq_ack),
  .irq_pending(irq_pending), .irq_request(irq_request));
`default_nettype wire

/* File: tb/mirb_evt_src.sv */
// event source model standing in for the peripherals that raise requests
`timescale 1ns/10ps
`default_nettype none
module mirb_evt_src
(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic [8:0] trig,
  output logic      [8:0] evt
);
  // one-cycle pulses on the system clock, as timers and units make them
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      evt <= 9'h000;
    else
      evt <= trig;
endmodule
`default_nettype wire

/* File: tb/mirb_bank_tb.sv */
// self-checking testbench of the interrupt request and enable bank
`timescale 1ns/10ps
`default_nettype none
module mirb_bank_tb;
  logic       clock, nrst, reg_wr, reg_rd, ext_pin, irq_ack, irq_request;
  logic [2:0] reg_sel, irq_ack_vec;
  logic [7:0] reg_wdata, reg_rdata, irq_pending;
  logic [8:0] trig, evt;
  int         failures, checks;
  logic [7:0] masks [8] = '{8'h03, 8'h7f, 8'hff, 8'h11, 8'h33, 8'h33, 8'h00, 8'h00};

  mirb_evt_src src (.clock(clock), .nrst(nrst), .trig(trig), .evt(evt));
  mirb_bank #(.LARGE_VARIANT(1'b1)) dut (.clock(clock), .nrst(nrst), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ext_pin(ext_pin),
    .touch_evt(evt[0]), .serial_evt(evt[1]), .tba_evt(evt[2]), .tbb_evt(evt[3]), .eeprom_evt(evt[4]),
    .pa_evt(evt[5]), .pp_evt(evt[6]), .ca_evt(evt[7]), .cp_evt(evt[8]), .irq_ack(irq_ack),
    .irq_ack_vec(irq_ack_vec), .irq_pending(irq_pending), .irq_request(irq_request));

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge clock);
    reg_sel <= s;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] s, input logic [7:0] e);
    @(posedge clock);
    reg_sel <= s;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, e);
  endtask
  // model pulse lands one edge later, flag one edge after that
  task automatic pulse(input logic [8:0] m);
    @(posedge clock);
    trig <= m;
    @(posedge clock);
    trig <= 9'h000;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic ack(input logic [2:0] v);
    @(posedge clock);
    irq_ack <= 1'b1;
    irq_ack_vec <= v;
    @(posedge clock);
    irq_ack <= 1'b0;
    #1;
  endtask
  task automatic set_pin(input logic v);
    @(posedge clock);
    ext_pin <= v;
    repeat (5) @(posedge clock);
    #1;
  endtask

  task automatic t_reset;
    for (int i = 0; i < 8; i++)
      rd(3'(i), 8'h00);
  endtask
  task automatic t_masks;
    for (int i = 0; i < 8; i++)
      wr(3'(i), 8'hff);
    for (int i = 0; i < 8; i++)
      rd(3'(i), masks[i]);
    for (int i = 0; i < 8; i++)
      wr(3'(i), 8'h00);
    rd(3'h1, 8'h00);
  endtask
  task automatic t_events;
    wr(3'h1, 8'h0f);
    wr(3'h2, 8'h0f);
    pulse(9'h01f);
    rd(3'h1, 8'h2f);
    rd(3'h2, 8'hff);
    chk("irq_pending", irq_pending, 8'h7a);
    chk("irq_request", {7'h00, irq_request}, 8'h01);
    ack(3'h1);
    chk("irq_pending", irq_pending, 8'h00);
    chk("irq_request", {7'h00, irq_request}, 8'h00);
    rd(3'h1, 8'h0e);
  endtask
  task automatic t_gated;
    wr(3'h1, 8'h01);
    wr(3'h2, 8'h00);
    pulse(9'h002);
    rd(3'h2, 8'h10);
    chk("irq_pending", irq_pending, 8'h00);
  endtask
  task automatic t_group;
    wr(3'h2, 8'h00);
    wr(3'h4, 8'h03);
    wr(3'h5, 8'h03);
    wr(3'h3, 8'h01);
    wr(3'h1, 8'h09);
    pulse(9'h1e0);
    rd(3'h4, 8'h33);
    rd(3'h5, 8'h33);
    rd(3'h1, 8'h49);
    rd(3'h3, 8'h11);
    chk("irq_pending", irq_pending, 8'h84);
    ack(3'h2);
    rd(3'h1, 8'h08);
    rd(3'h4, 8'h33);
  endtask
  // group 1 and pin service, then a service colliding with a new event
  task automatic t_service;
    wr(3'h1, 8'h01);
    #1 chk("irq_pending", irq_pending, 8'h80);
    ack(3'h7);
    rd(3'h3, 8'h01);
    rd(3'h5, 8'h33);
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h03);
    set_pin(1'b1);
    chk("irq_pending", irq_pending, 8'h01);
    chk("irq_request", {7'h00, irq_request}, 8'h01);
    ack(3'h0);
    chk("irq_request", {7'h00, irq_request}, 8'h00);
    rd(3'h1, 8'h02);
    set_pin(1'b0);
    wr(3'h1, 8'h05);
    pulse(9'h001);
    @(posedge clock);
    trig <= 9'h001;
    @(posedge clock);
    trig <= 9'h000;
    irq_ack <= 1'b1;
    irq_ack_vec <= 3'h1;
    @(posedge clock);
    irq_ack <= 1'b0;
    #1 chk("irq_pending", irq_pending, 8'h00);
    rd(3'h1, 8'h24);
  endtask
  task automatic t_rerst;
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
  endtask
  task automatic t_edge;
    for (int c = 0; c < 4; c++)
    begin
      wr(3'h0, 8'(c));
      wr(3'h1, 8'h00);
      set_pin(1'b1);
      rd(3'h1, {3'h0, c[0], 4'h0});
      wr(3'h1, 8'h00);
      set_pin(1'b0);
      rd(3'h1, {3'h0, c[1], 4'h0});
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    #200000;
    failures++;
    report_and_stop();
  end
  initial
  begin
    nrst = 1'b0;
    reg_sel = 3'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    ext_pin = 1'b0;
    irq_ack = 1'b0;
    irq_ack_vec = 3'h0;
    trig = 9'h000;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_masks();
    t_events();
    t_gated();
    t_group();
    t_service();
    t_rerst();
    t_edge();
    report_and_stop();
  end
endmodule
`default_nettype wire
